// File: rtl/fifo_sram_pkg.sv
// constants and types for the shared frame fifo memory
// assumes a single clock domain, 64-bit memory words
package fifo_sram_pkg;
    localparam int             WORD_BITS       = 64;
    localparam int             MEM_WORDS       = 432;
    localparam int             ADDR_BITS       = 9;
    localparam int             CNT_BITS        = 8;
    localparam int             NUM_FIFOS       = 3;
    localparam int             FIFO_RX         = 0;
    localparam int             FIFO_TX0        = 1;
    localparam int             FIFO_TX1        = 2;
    // region map in 64-bit words
    localparam logic [8:0]     RX_BASE         = 9'h000;
    localparam logic [8:0]     TX0_BASE        = 9'h0C0;
    localparam logic [8:0]     TX1_BASE        = 9'h120;
    localparam logic [8:0]     LIST_BASE       = 9'h180;
    localparam logic [7:0]     RX_WORDS        = 8'hC0;
    localparam logic [7:0]     TX_WORDS        = 8'h60;
    localparam logic [7:0]     TX_MERGED_WORDS = 8'hC0;
    localparam logic [7:0]     LIST_WORDS      = 8'h10;
    localparam int             MIN_FIFO_BYTES  = 500;
    localparam int             WORD_BYTES      = 8;
    // staging buffer in the host write path
    localparam int             STAGE_DEPTH     = 16;
    localparam int             STAGE_BITS      = WORD_BITS + 1;
    // slot schedule
    localparam int             PHASE_BITS      = 2;
    localparam logic [1:0]     ENG_PHASE       = 2'h1;
    localparam logic [1:0]     SPARE_PHASE     = 2'h3;
    localparam logic [CNT_BITS-1:0] CNT_ONE    = 8'h01;

    typedef enum logic [1:0] {OWN_HOST, OWN_ENG, OWN_DIAG, OWN_IDLE} slot_owner_type;
endpackage

// File: rtl/stage_fifo.sv
// flop-based synchronous word fifo with valid/ready on both sides
// assumes one clock; full stalls the source through ready
`timescale 1ns/10ps
module stage_fifo #(
    parameter int WIDTH = 65,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // streams
    stream_if.snk     in_s,
    stream_if.src     out_s
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wp_q;
    logic [PW-1:0]    rp_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_s.ready  = (cnt_q != (PW+1)'(DEPTH));
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data  = mem_q[rp_q];
    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_s.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + PW'(1);
            end
            if (pop) begin
                rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + PW'(1);
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // stage_fifo

// File: rtl/stream_if.sv
// valid/ready word stream between the block's own modules
// assumes source and sink share clk
`timescale 1ns/10ps
interface stream_if #(parameter int W = 65);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: rtl/tdm_fifo_sram_buffer.sv
// shared frame memory with rx/tx circular fifos and tdm access
// assumes host side, protocol engine and diag port share clk
`timescale 1ns/10ps

// Operation
// - memory clocked by the host bus clock
// - fixed time-division slots, no arbitration
// - every second cycle to host, 64-bit
// - engine gets one in four, 64-bit
// - spare slots may go to engine
// - direct io reads/writes array for diagnostics
// - 3.375K bytes, three 128-byte lists
// - one 1.5K-byte receive region
// - two 0.75K-byte transmit regions
// - single-channel mode merges transmit into 1.5K
// - pointer and counter registers per circular fifo
// - separate pointer set per fifo channel
// - each fifo at least 500 bytes
module tdm_fifo_sram_buffer
    import fifo_sram_pkg::*;
(
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    // mode
    input  wire logic                                 single_chan,
    // host side write into transmit fifos
    input  wire logic                                 host_wr_valid,
    output logic                                      host_wr_ready,
    input  wire logic                                 host_wr_chan,
    input  wire logic [fifo_sram_pkg::WORD_BITS-1:0]  host_wr_data,
    // host side read from receive fifo
    input  wire logic                                 host_rd_req,
    output logic                                      host_rd_ack,
    output logic                                      host_rd_valid,
    output logic [fifo_sram_pkg::WORD_BITS-1:0]       host_rd_data,
    // protocol engine
    input  wire logic                                 eng_req,
    input  wire logic                                 eng_we,
    input  wire logic                                 eng_chan,
    input  wire logic [fifo_sram_pkg::WORD_BITS-1:0]  eng_wdata,
    output logic                                      eng_ack,
    output logic                                      eng_rvalid,
    output logic [fifo_sram_pkg::WORD_BITS-1:0]       eng_rdata,
    // host direct io diagnostic access
    input  wire logic                                 dio_req,
    input  wire logic                                 dio_we,
    input  wire logic [fifo_sram_pkg::ADDR_BITS-1:0]  dio_addr,
    input  wire logic [fifo_sram_pkg::WORD_BITS-1:0]  dio_wdata,
    output logic                                      dio_ack,
    output logic                                      dio_rvalid,
    output logic [fifo_sram_pkg::WORD_BITS-1:0]       dio_rdata,
    // fill levels in words
    output logic [fifo_sram_pkg::CNT_BITS-1:0]        rx_level,
    output logic [fifo_sram_pkg::CNT_BITS-1:0]        tx0_level,
    output logic [fifo_sram_pkg::CNT_BITS-1:0]        tx1_level
);
    import fifo_sram_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    slot_owner_type        owner;
    logic [WORD_BITS-1:0]  mem_q [MEM_WORDS];
    logic [WORD_BITS-1:0]  rdata_q;
    logic                  host_rv_q;
    logic                  eng_rv_q;
    logic                  dio_rv_q;

    logic [CNT_BITS-1:0]   wr_q   [NUM_FIFOS];
    logic [CNT_BITS-1:0]   rd_q   [NUM_FIFOS];
    logic [CNT_BITS-1:0]   cnt_q  [NUM_FIFOS];
    logic [CNT_BITS-1:0]   size   [NUM_FIFOS];
    logic [ADDR_BITS-1:0]  base   [NUM_FIFOS];
    logic [NUM_FIFOS-1:0]  full;
    logic [NUM_FIFOS-1:0]  empty;
    logic [NUM_FIFOS-1:0]  push;
    logic [NUM_FIFOS-1:0]  pop;

    logic                  host_rd_go;
    logic                  host_wr_go;
    logic                  eng_go;
    logic                  dio_go;
    logic [1:0]            host_tx;
    logic [1:0]            eng_tx;
    logic                  mem_we;
    logic [ADDR_BITS-1:0]  mem_addr;
    logic [WORD_BITS-1:0]  mem_wdata;

    stream_if #(.W(STAGE_BITS)) st_in ();
    stream_if #(.W(STAGE_BITS)) st_out ();

    ////////////////////////////////////////////////////////////////////////////
    // host write staging buffer

    assign st_in.valid   = host_wr_valid;
    assign st_in.data    = {host_wr_chan, host_wr_data};
    assign host_wr_ready = st_in.ready;

    stage_fifo #(
        .WIDTH (STAGE_BITS),
        .DEPTH (STAGE_DEPTH)
    ) u_stage (
        .clk   (clk),
        .rst   (rst),
        .in_s  (st_in),
        .out_s (st_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // slot schedule

    tdm_slot_sched u_sched (
        .clk     (clk),
        .rst     (rst),
        .eng_req (eng_req),
        .dio_req (dio_req),
        .owner   (owner)
    );

    ////////////////////////////////////////////////////////////////////////////
    // region map

    always_comb begin
        base[FIFO_RX]  = RX_BASE;
        base[FIFO_TX0] = TX0_BASE;
        base[FIFO_TX1] = TX1_BASE;
        size[FIFO_RX]  = RX_WORDS;
        size[FIFO_TX0] = single_chan ? TX_MERGED_WORDS : TX_WORDS;
        size[FIFO_TX1] = TX_WORDS;
    end

    // channel 1 folds onto channel 0 in single-channel mode
    assign host_tx = (single_chan || !st_out.data[WORD_BITS]) ? 2'(FIFO_TX0)
                                                              : 2'(FIFO_TX1);
    assign eng_tx  = (single_chan || !eng_chan) ? 2'(FIFO_TX0) : 2'(FIFO_TX1);

    ////////////////////////////////////////////////////////////////////////////
    // slot use decisions

    always_comb begin
        host_rd_go = (owner == OWN_HOST) && host_rd_req && !empty[FIFO_RX];
        host_wr_go = (owner == OWN_HOST) && !host_rd_go && st_out.valid
                     && !full[host_tx];
        eng_go     = (owner == OWN_ENG) && eng_req
                     && (eng_we ? !full[FIFO_RX] : !empty[eng_tx]);
        dio_go     = (owner == OWN_DIAG);
    end

    assign st_out.ready = host_wr_go;
    assign host_rd_ack  = host_rd_go;
    assign eng_ack      = eng_go;
    assign dio_ack      = dio_go;

    always_comb begin
        push = '0;
        pop  = '0;
        if (host_rd_go) begin
            pop[FIFO_RX] = 1'b1;
        end
        if (host_wr_go) begin
            push[host_tx] = 1'b1;
        end
        if (eng_go && eng_we) begin
            push[FIFO_RX] = 1'b1;
        end
        if (eng_go && !eng_we) begin
            pop[eng_tx] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory port mux

    always_comb begin
        mem_we    = 1'b0;
        mem_addr  = '0;
        mem_wdata = '0;
        if (host_rd_go) begin
            mem_addr = base[FIFO_RX] + ADDR_BITS'(rd_q[FIFO_RX]);
        end else if (host_wr_go) begin
            mem_we    = 1'b1;
            mem_addr  = base[host_tx] + ADDR_BITS'(wr_q[host_tx]);
            mem_wdata = st_out.data[WORD_BITS-1:0];
        end else if (eng_go && eng_we) begin
            mem_we    = 1'b1;
            mem_addr  = base[FIFO_RX] + ADDR_BITS'(wr_q[FIFO_RX]);
            mem_wdata = eng_wdata;
        end else if (eng_go) begin
            mem_addr = base[eng_tx] + ADDR_BITS'(rd_q[eng_tx]);
        end else if (dio_go) begin
            mem_we    = dio_we;
            mem_addr  = dio_addr;
            mem_wdata = dio_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory array, one access per cycle

    always_ff @(posedge clk) begin
        if (mem_we && (mem_addr < ADDR_BITS'(MEM_WORDS))) begin
            mem_q[mem_addr] <= mem_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (mem_addr < ADDR_BITS'(MEM_WORDS)) begin
            rdata_q <= mem_q[mem_addr];
        end else begin
            rdata_q <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            host_rv_q <= 1'b0;
            eng_rv_q  <= 1'b0;
            dio_rv_q  <= 1'b0;
        end else begin
            host_rv_q <= host_rd_go;
            eng_rv_q  <= eng_go && !eng_we;
            dio_rv_q  <= dio_go && !dio_we;
        end
    end

    assign host_rd_valid = host_rv_q;
    assign eng_rvalid    = eng_rv_q;
    assign dio_rvalid    = dio_rv_q;
    assign host_rd_data  = rdata_q;
    assign eng_rdata     = rdata_q;
    assign dio_rdata     = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // pointer and counter sets, one per fifo

    for (genvar i = 0; i < NUM_FIFOS; i++) begin : g_ptr
        assign full[i]  = (cnt_q[i] >= size[i]);
        assign empty[i] = (cnt_q[i] == '0);

        always_ff @(posedge clk) begin
            if (rst) begin
                wr_q[i]  <= '0;
                rd_q[i]  <= '0;
                cnt_q[i] <= '0;
            end else begin
                if (push[i]) begin
                    wr_q[i] <= (wr_q[i] == size[i] - CNT_ONE) ? '0
                                                               : wr_q[i] + CNT_ONE;
                end
                if (pop[i]) begin
                    rd_q[i] <= (rd_q[i] == size[i] - CNT_ONE) ? '0
                                                               : rd_q[i] + CNT_ONE;
                end
                cnt_q[i] <= cnt_q[i] + CNT_BITS'(push[i]) - CNT_BITS'(pop[i]);
            end
        end
    end

    assign rx_level  = cnt_q[FIFO_RX];
    assign tx0_level = cnt_q[FIFO_TX0];
    assign tx1_level = cnt_q[FIFO_TX1];

    // smallest region is 96 words of 8 bytes, above the latency floor
    localparam int SMALLEST_BYTES = int'(TX_WORDS) * WORD_BYTES;
    logic [CNT_BITS-1:0] unused_list;
    assign unused_list = LIST_WORDS;

endmodule // tdm_fifo_sram_buffer

// File: rtl/tdm_slot_sched.sv
// fixed four-phase memory slot schedule
// assumes requests are levels sampled every cycle
`timescale 1ns/10ps
module tdm_slot_sched
    import fifo_sram_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // spare slot candidates
    input  wire logic                    eng_req,
    input  wire logic                    dio_req,
    // owner of the current cycle
    output fifo_sram_pkg::slot_owner_type owner
);
    logic [PHASE_BITS-1:0] phase_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + PHASE_BITS'(1);
        end
    end

    always_comb begin
        if (!phase_q[0]) begin
            owner = OWN_HOST;
        end else if (phase_q == ENG_PHASE) begin
            owner = OWN_ENG;
        end else if (eng_req) begin
            owner = OWN_ENG;
        end else if (dio_req) begin
            owner = OWN_DIAG;
        end else begin
            owner = OWN_IDLE;
        end
    end
endmodule // tdm_slot_sched

// File: tb/engine_model.sv
// behavioural protocol engine on the block's engine port
// assumes requests change at the falling edge of clk
`timescale 1ns/10ps
module engine_model (
    // clock
    input  wire logic        clk,
    // engine port
    output logic             eng_req,
    output logic             eng_we,
    output logic             eng_chan,
    output logic [63:0]      eng_wdata,
    input  wire logic        eng_ack,
    input  wire logic        eng_rvalid,
    input  wire logic [63:0] eng_rdata
);
    initial begin
        eng_req = 1'b0;
        eng_we = 1'b0;
        eng_chan = 1'b0;
        eng_wdata = 64'h0;
    end

    ////////////////////////////////////////
    // held until ack for up to 64 cycles, read data taken one cycle later
    task automatic xfer(input logic we, input logic ch, input logic [63:0] wd,
                        output logic [63:0] rd, output logic ok);
        int n;
        ok = 1'b0;
        @(negedge clk);
        eng_we = we;
        eng_chan = ch;
        eng_wdata = wd;
        eng_req = 1'b1;
        for (n = 0; n < 64 && !ok; n++) begin
            #1;
            if (eng_ack) ok = 1'b1;
            else @(negedge clk);
        end
        @(negedge clk);
        rd = eng_rdata;
        ok = ok && (we || eng_rvalid);
        eng_req = 1'b0;
        eng_wdata = ~wd;
    endtask
endmodule // engine_model

// File: tb/tdm_fifo_sram_buffer_bench.sv
// self-checking bench for the shared frame fifo memory
// assumes engine_model on the engine port and the bound checker
`timescale 1ns/10ps
module tdm_fifo_sram_buffer_bench;
    import fifo_sram_pkg::*;
    logic        clk, rst, single_chan, host_wr_valid, host_wr_ready, host_wr_chan;
    logic        host_rd_req, host_rd_ack, host_rd_valid, dio_req, dio_we, dio_ack, dio_rvalid;
    logic        eng_req, eng_we, eng_chan, eng_ack, eng_rvalid;
    logic [63:0] host_wr_data, host_rd_data, eng_wdata, eng_rdata, dio_wdata, dio_rdata, r;
    logic [8:0]  dio_addr;
    logic [7:0]  rx_level, tx0_level, tx1_level;
    logic        ok;
    int          failures = 0;
    int          compares = 0;

    tdm_fifo_sram_buffer uut (.clk, .rst, .single_chan, .host_wr_valid, .host_wr_ready,
        .host_wr_chan, .host_wr_data, .host_rd_req, .host_rd_ack, .host_rd_valid, .host_rd_data,
        .eng_req, .eng_we, .eng_chan, .eng_wdata, .eng_ack, .eng_rvalid, .eng_rdata, .dio_req,
        .dio_we, .dio_addr, .dio_wdata, .dio_ack, .dio_rvalid, .dio_rdata, .rx_level,
        .tx0_level, .tx1_level);
    engine_model eng (.clk, .eng_req, .eng_we, .eng_chan, .eng_wdata, .eng_ack,
        .eng_rvalid, .eng_rdata);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////
    function automatic logic [63:0] pat(input int i);
        return {32'(i), 32'(i) ^ 32'hC35A0000};
    endfunction

    task automatic close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic lost;
        failures++;
        close_out;
    endtask

    task automatic lvl(input int w, input logic [7:0] exp);
        logic [7:0] l;
        int n;
        for (n = 0; n < 300; n++) begin
            @(negedge clk);
            l = (w == 0) ? rx_level : (w == 1) ? tx0_level : tx1_level;
            if (l === exp) break;
        end
        cmp({56'h0, l}, {56'h0, exp});
    endtask

    task automatic host_wr(input logic ch, input logic [63:0] d);
        int n;
        @(negedge clk);
        host_wr_valid = 1'b1;
        host_wr_chan = ch;
        host_wr_data = d;
        for (n = 0; n < 64; n++) begin
            #1;
            if (host_wr_ready) break;
            @(negedge clk);
        end
        if (n == 64) lost;
        @(negedge clk);
        host_wr_valid = 1'b0;
        host_wr_data = ~d;
    endtask

    task automatic host_rd(output logic [63:0] d);
        int n;
        @(negedge clk);
        host_rd_req = 1'b1;
        for (n = 0; n < 64; n++) begin
            #1;
            if (host_rd_ack) break;
            @(negedge clk);
        end
        if (n == 64) lost;
        @(negedge clk);
        d = host_rd_valid ? host_rd_data : 64'hX;
        host_rd_req = 1'b0;
    endtask

    task automatic host_direct_io(input logic we, input logic [8:0] a, input logic [63:0] wd,
                       output logic [63:0] d);
        int n;
        @(negedge clk);
        {dio_req, dio_we, dio_addr, dio_wdata} = {1'b1, we, a, wd};
        for (n = 0; n < 64; n++) begin
            #1;
            if (dio_ack) break;
            @(negedge clk);
        end
        if (n == 64) lost;
        @(negedge clk);
        d = (we || dio_rvalid) ? dio_rdata : 64'hX;
        {dio_req, dio_wdata} = {1'b0, ~wd};
    endtask

    task automatic eng_op(input logic we, input logic ch, input logic [63:0] wd);
        eng.xfer(we, ch, wd, r, ok);
        if (!ok) lost;
    endtask

    ////////////////////////////////////////
    task automatic t_reset;
        cmp({40'h0, rx_level, tx0_level, tx1_level}, 64'h0);
        cmp({60'h0, host_wr_ready, host_rd_valid, eng_rvalid, dio_rvalid}, 64'h8);
        $display("test reset done");
    endtask

    task automatic t_rx;
        for (int i = 0; i < 3; i++) eng_op(1'b1, 1'b0, pat(i));
        lvl(0, 8'h03);
        for (int i = 0; i < 3; i++) begin
            host_rd(r);
            cmp(r, pat(i));
        end
        lvl(0, 8'h00);
        $display("test rx path done");
    endtask

    task automatic t_tx;
        host_wr(1'b0, pat(500));
        for (int i = 0; i < 112; i++) host_wr(1'b1, pat(i));
        lvl(2, TX_WORDS);
        cmp({63'h0, host_wr_ready}, 64'h0);
        cmp({56'h0, tx0_level}, 64'h1);
        for (int i = 0; i < 112; i++) begin
            eng_op(1'b0, 1'b1, 64'h0);
            cmp(r, pat(i));
        end
        eng_op(1'b0, 1'b0, 64'h0);
        cmp(r, pat(500));
        lvl(2, 8'h00);
        $display("test tx path done");
    endtask

    task automatic t_single;
        single_chan = 1'b1;
        for (int i = 0; i < 150; i++) host_wr(1'b1, pat(i + 900));
        lvl(1, 8'h96);
        cmp({56'h0, tx1_level}, 64'h0);
        for (int i = 0; i < 150; i++) begin
            eng_op(1'b0, 1'b1, 64'h0);
            cmp(r, pat(i + 900));
        end
        lvl(1, 8'h00);
        single_chan = 1'b0;
        $display("test single channel done");
    endtask

    task automatic t_diag;
        host_direct_io(1'b1, 9'h1AF, pat(77), r);
        host_direct_io(1'b1, 9'h1B0, pat(78), r);
        host_direct_io(1'b0, 9'h1AF, 64'h0, r);
        cmp(r, pat(77));
        host_direct_io(1'b0, 9'h1B0, 64'h0, r);
        cmp(r, 64'h0);
        $display("test diag access done");
    endtask

    initial begin
        {rst, single_chan, host_wr_valid, host_wr_chan, host_rd_req} = 5'h10;
        {dio_req, dio_we, dio_addr, dio_wdata, host_wr_data} = '0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_rx();
        t_tx();
        t_single();
        t_diag();
        close_out();
    end
endmodule // tdm_fifo_sram_buffer_bench

// File: tb/tdm_fifo_sram_buffer_chk.sv
// port checker for the shared frame fifo memory
// assumes sync active-high rst and slot phase 0 on the first cycle after it
`timescale 1ns/10ps
module tdm_fifo_sram_buffer_chk
    import fifo_sram_pkg::*;
(
    // clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst,
    // watched ports
    input  wire logic                                eng_req,
    input  wire logic                                eng_we,
    input  wire logic                                eng_ack,
    input  wire logic                                eng_rvalid,
    input  wire logic                                dio_we,
    input  wire logic                                dio_ack,
    input  wire logic                                dio_rvalid,
    input  wire logic                                host_rd_req,
    input  wire logic                                host_rd_ack,
    input  wire logic                                host_rd_valid,
    input  wire logic [fifo_sram_pkg::CNT_BITS-1:0]  rx_level
);
    logic [1:0] phase_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    always_ff @(posedge clk) begin
        if (rst) phase_q <= 2'h0;
        else phase_q <= phase_q + 2'h1;
    end

    ////////////////////////////////////////
    chk_host_slot: assert property (host_rd_ack |-> !phase_q[0])
        else $error("host ack outside a host slot");
    chk_eng_slot: assert property (eng_ack |-> phase_q[0])
        else $error("engine ack outside an engine slot");
    chk_diag_spare: assert property (dio_ack |-> phase_q == 2'h3 && !eng_req)
        else $error("diag ack outside a free spare slot");
    chk_host_answer: assert property (host_rd_ack |=> host_rd_valid ##1 !host_rd_valid)
        else $error("host read data not one cycle after ack");
    chk_eng_answer: assert property (eng_ack && !eng_we |=> eng_rvalid)
        else $error("engine read data missing");
    chk_diag_answer: assert property (dio_ack && !dio_we |=> dio_rvalid)
        else $error("diag read data missing");
    chk_rx_drain: assert property (host_rd_ack |=> rx_level == $past(rx_level) - CNT_ONE)
        else $error("rx level not lowered by a host read");
    chk_rx_fill: assert property (eng_ack && eng_we |=> rx_level == $past(rx_level) + CNT_ONE)
        else $error("rx level not raised by an engine write");
    chk_rx_empty: assert property (host_rd_ack |-> rx_level != 8'h00)
        else $error("host read taken from empty rx");
    chk_rx_full: assert property (eng_ack && eng_we |-> rx_level < RX_WORDS)
        else $error("engine write taken into full rx");
    chk_host_grant: assert property (!phase_q[0] && host_rd_req && rx_level != 8'h00 |-> host_rd_ack)
        else $error("host read refused in its own slot");
    chk_eng_grant: assert property (phase_q[0] && eng_req && eng_we && rx_level < RX_WORDS |-> eng_ack)
        else $error("engine write refused in an engine or spare slot");

    cover property (host_rd_ack);
    cover property (eng_ack && eng_we);
    cover property (dio_ack);
endmodule // tdm_fifo_sram_buffer_chk

bind tdm_fifo_sram_buffer tdm_fifo_sram_buffer_chk chk (.clk, .rst, .eng_req, .eng_we,
    .eng_ack, .eng_rvalid, .dio_we, .dio_ack, .dio_rvalid, .host_rd_req, .host_rd_ack,
    .host_rd_valid,
    .rx_level);
